/* File: hdl/rmls_defs.vh */
// Constants of the ring detect mode and line condition status block.
// Assumes inclusion by bare name from the design file.
`ifndef RMLS_DEFS_VH
`define RMLS_DEFS_VH

// Register indices; the byte address is four times the index.
`define RMLS_IDX_RING_MODE 8'h12
`define RMLS_IDX_LINE_STATUS 8'h13
`define RMLS_IDX_STICKY_OVERLOAD 8'h14
`define RMLS_IDX_IRQ_STATUS 8'h15
`define RMLS_IDX_IRQ_MASK 8'h16

// Field positions.
`define RMLS_BIT_RECT_SEL 1
`define RMLS_BIT_RSVD_WR 2
`define RMLS_BIT_OVERCURRENT 0
`define RMLS_BIT_DROPOUT 1
`define RMLS_BIT_SC_OVERLOAD 2
`define RMLS_BIT_STICKY_OVERLOAD 0

// Interrupt event bits.
`define RMLS_EV_OVERLOAD 0
`define RMLS_EV_DROPOUT 1
`define RMLS_EV_OVERCURRENT 2
`define RMLS_EV_ONESHOT 3
`define RMLS_EV_COUNT 4

// Reset values.
`define RMLS_RST_RING_MODE 8'h00
`define RMLS_RST_RECT_SEL 1'b0
`define RMLS_RST_LINE_STATUS 8'h00
`define RMLS_RST_IRQ 4'h0

// Timing: one-shot length in milliseconds and the clock rate in kHz.
`define RMLS_ONESHOT_MS 5000
`define RMLS_CLK_KHZ 50000
`define RMLS_ONESHOT_CYCLES (`RMLS_ONESHOT_MS * `RMLS_CLK_KHZ)

`endif

/* File: hdl/rmls_top.v */
// Ring detect output selection and line condition status with an APB slave.
// Assumes all detector inputs are synchronous to pclk and already filtered.
//
// Summary of operation
// [R1] Reserved ring mode bit 2 accepts any value.
// [R2] Validation off: rectifier selects half or full wave.
// [R3] Validation on: envelope or one-shot drives ring pin.
// [R4] One-shot starts on crossing, ends after timeout.
// [R5] Self-clearing overload follows the receive overload level.
// [R6] Only off-hook counter masks it; billing enable ignored.
// [R7] Dropout reads one without loop current.
// [R8] Dropout also one when on-hook and enabled.
// [R9] Overcurrent threshold chosen by current limit setting.
// [R10] Overcurrent bit reports the detected overcurrent condition.
// [R11] Writing zero clears sticky overload and its flag.
// [R12] Reserved bits read zero; status writes are ignored.
`timescale 1ns/1ps
`include "rmls_defs.vh"

module rmls_top #(
    parameter ONESHOT_CYCLES = `RMLS_ONESHOT_CYCLES,
    parameter CNT_W = 28
)(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire pready,
    output reg [31:0] prdata,
    output reg pslverr,
    input wire ring_validation_enable,
    input wire half_wave_detect,
    input wire full_wave_detect,
    input wire validated_envelope,
    input wire ring_threshold_cross,
    input wire rx_overload_level,
    input wire offhook_counter_mask,
    input wire loop_current_flowing,
    input wire offhook,
    input wire line_side_enabled,
    input wire current_limit_setting,
    input wire overcurrent_160ma,
    input wire overcurrent_60ma,
    output reg ring_detect_pin,
    output wire irq
);

    // Byte addresses derived from the register indices.
    localparam [11:0] ADDR_RING_MODE = {2'h0, `RMLS_IDX_RING_MODE, 2'h0};
    localparam [11:0] ADDR_LINE_STATUS = {2'h0, `RMLS_IDX_LINE_STATUS, 2'h0};
    localparam [11:0] ADDR_STICKY_OVERLOAD = {2'h0, `RMLS_IDX_STICKY_OVERLOAD, 2'h0};
    localparam [11:0] ADDR_IRQ_STATUS = {2'h0, `RMLS_IDX_IRQ_STATUS, 2'h0};
    localparam [11:0] ADDR_IRQ_MASK = {2'h0, `RMLS_IDX_IRQ_MASK, 2'h0};
    // The last count is cut to the counter width on purpose; CNT_W must hold it.
    localparam [31:0] ONESHOT_LAST_W = ONESHOT_CYCLES - 1;
    localparam [CNT_W-1:0] ONESHOT_LAST = ONESHOT_LAST_W[CNT_W-1:0];

    reg rectifier_select; // Stored rectifier select bit.
    reg [7:0] line_condition_status; // Read-only status image.
    reg sticky_receive_overload; // Held until software writes zero.
    reg [`RMLS_EV_COUNT-1:0] irq_status; // Sticky event bits.
    reg [`RMLS_EV_COUNT-1:0] irq_mask; // One enables an event onto irq.
    reg [`RMLS_EV_COUNT-1:0] irq_read; // Status bits captured by a pending read.
    reg oneshot_active; // Unqualified ring one-shot running.
    reg [CNT_W-1:0] oneshot_count; // Cycles elapsed in the one-shot.
    // Edge history of the crossing input; it resets to the idle level low,
    // so a crossing already high at the release of reset starts a one-shot.
    reg cross_last; // Previous threshold crossing level.
    reg [7:0] prev_status; // Previous status, for event edges.

    wire setup_phase; // First cycle of an APB transfer.
    wire access_wr; // Write taking effect at this edge.
    wire access_rd; // Read completing at this edge.
    wire cross_rise; // Threshold crossing began.
    wire [7:0] next_status; // Status image for the next cycle.
    wire [`RMLS_EV_COUNT-1:0] events; // One-cycle event pulses.

    // The slave never stalls: every access phase completes in one cycle.
    assign pready = 1'b1;
    // Setup is the cycle in which read data is captured.
    assign setup_phase = psel & ~penable;
    assign access_wr = psel & penable & pwrite;
    assign access_rd = psel & penable & ~pwrite;
    // A crossing held high gives one edge only.
    assign cross_rise = ring_threshold_cross & ~cross_last;

    // Status bits are computed from the detector levels.
    assign next_status[7:3] = 5'h00; // [R12]
    assign next_status[`RMLS_BIT_SC_OVERLOAD] =
        rx_overload_level & ~offhook_counter_mask; // [R5] [R6]
    // Dropout is a pure level of the line conditions; it is never latched.
    assign next_status[`RMLS_BIT_DROPOUT] =
        ~loop_current_flowing | (~offhook & line_side_enabled); // [R7] [R8]
    // Overcurrent follows the comparator that the current limit selects.
    assign next_status[`RMLS_BIT_OVERCURRENT] =
        current_limit_setting ? overcurrent_60ma : overcurrent_160ma; // [R9] [R10]

    // Events 0 to 2 are the rising edges of each status condition.
    assign events[`RMLS_EV_OVERLOAD] = next_status[`RMLS_BIT_SC_OVERLOAD] &
        ~prev_status[`RMLS_BIT_SC_OVERLOAD];
    assign events[`RMLS_EV_DROPOUT] = next_status[`RMLS_BIT_DROPOUT] &
        ~prev_status[`RMLS_BIT_DROPOUT];
    assign events[`RMLS_EV_OVERCURRENT] = next_status[`RMLS_BIT_OVERCURRENT] &
        ~prev_status[`RMLS_BIT_OVERCURRENT];
    // A crossing while the one-shot runs is ignored, so it raises no event.
    assign events[`RMLS_EV_ONESHOT] = cross_rise & ~oneshot_active;

    // Level interrupt while any unmasked sticky bit is set.
    assign irq = |(irq_status & irq_mask);

    // Status image and edge history refresh on every clock.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            line_condition_status <= `RMLS_RST_LINE_STATUS;
            prev_status <= `RMLS_RST_LINE_STATUS;
            cross_last <= 1'b0;
        end
        else
        begin
            // Host writes never reach this image, so it stays read-only.
            line_condition_status <= next_status; // [R12]
            prev_status <= next_status;
            // Sampled every cycle so the edge detector never misses a burst.
            cross_last <= ring_threshold_cross;
        end
    end

    // The one-shot ignores further crossings while it runs; a fresh ring
    // burst after the timeout starts a new pulse.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            oneshot_active <= 1'b0;
            oneshot_count <= {CNT_W{1'b0}};
        end
        else if (!oneshot_active)
        begin
            // Idle: wait for the threshold to be crossed.
            if (cross_rise)
            begin
                oneshot_active <= 1'b1; // [R4]
                oneshot_count <= {CNT_W{1'b0}};
            end
        end
        else if (oneshot_count == ONESHOT_LAST)
        begin
            // Fixed timeout reached: the pulse ends.
            oneshot_active <= 1'b0; // [R4]
            oneshot_count <= {CNT_W{1'b0}};
        end
        else
        begin
            oneshot_count <= oneshot_count + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // Ring detect pin multiplexer, registered so the pin is glitch free.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ring_detect_pin <= 1'b0;
        end
        else if (!ring_validation_enable)
        begin
            ring_detect_pin <= rectifier_select ? full_wave_detect
                                                : half_wave_detect; // [R2]
        end
        else
        begin
            ring_detect_pin <= rectifier_select ? oneshot_active
                                                : validated_envelope; // [R3]
        end
    end

    // Writable control registers.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // The stored bit is the only live field of the ring mode register.
            rectifier_select <= `RMLS_RST_RECT_SEL;
            irq_mask <= `RMLS_RST_IRQ;
        end
        else if (access_wr && pstrb[0])
        begin
            if (paddr == ADDR_RING_MODE)
            begin
                // Bit 2 is accepted and dropped; it has no function.
                rectifier_select <= pwdata[`RMLS_BIT_RECT_SEL]; // [R1]
            end
            else if (paddr == ADDR_IRQ_MASK)
            begin
                irq_mask <= pwdata[`RMLS_EV_COUNT-1:0];
            end
        end
    end

    // Sticky overload: set by the raw level, cleared by writing zero.
    // The set term wins so an overload in the clearing cycle survives.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sticky_receive_overload <= 1'b0;
        end
        else if (rx_overload_level)
        begin
            sticky_receive_overload <= 1'b1;
        end
        else if (access_wr && pstrb[0] && paddr == ADDR_STICKY_OVERLOAD &&
                 !pwdata[`RMLS_BIT_STICKY_OVERLOAD])
        begin
            sticky_receive_overload <= 1'b0; // [R11]
        end
    end

    // Interrupt status. A read clears only the bits it actually returned,
    // so an event landing between setup and access is never lost.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_status <= `RMLS_RST_IRQ;
        end
        else if (access_rd && paddr == ADDR_IRQ_STATUS)
        begin
            irq_status <= (irq_status & ~irq_read) | events;
        end
        // A clear that meets a new overload event leaves the flag set.
        else if (access_wr && pstrb[0] && paddr == ADDR_STICKY_OVERLOAD &&
                 !pwdata[`RMLS_BIT_STICKY_OVERLOAD])
        begin
            // Clearing the sticky overload clears its interrupt flag too.
            irq_status <= (irq_status &
                ~(`RMLS_RST_IRQ | (4'h1 << `RMLS_EV_OVERLOAD))) | events; // [R11]
        end
        else
        begin
            irq_status <= irq_status | events;
        end
    end

    // Read data and error are captured at setup so they come from flops;
    // the cost is that reads show state one cycle before the access edge.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            irq_read <= `RMLS_RST_IRQ;
        end
        else if (setup_phase)
        begin
            prdata <= 32'h00000000; // [R12]
            pslverr <= 1'b0;
            irq_read <= `RMLS_RST_IRQ;
            if (paddr == ADDR_RING_MODE)
            begin
                prdata[`RMLS_BIT_RECT_SEL] <= rectifier_select;
            end
            else if (paddr == ADDR_LINE_STATUS)
            begin
                // Writes here complete without error but change nothing.
                prdata[7:0] <= line_condition_status; // [R12]
            end
            else if (paddr == ADDR_STICKY_OVERLOAD)
            begin
                // Only bit 0 is live; the other bits read zero.
                prdata[`RMLS_BIT_STICKY_OVERLOAD] <= sticky_receive_overload;
            end
            else if (paddr == ADDR_IRQ_STATUS)
            begin
                prdata[`RMLS_EV_COUNT-1:0] <= irq_status;
                irq_read <= pwrite ? `RMLS_RST_IRQ : irq_status;
            end
            else if (paddr == ADDR_IRQ_MASK)
            begin
                prdata[`RMLS_EV_COUNT-1:0] <= irq_mask;
            end
            else
            begin
                // Unmapped address: error, zero data.
                pslverr <= 1'b1;
            end
        end
        else if (psel && penable)
        begin
            // Hold the error through the access phase; it drops on the next edge.
            pslverr <= pslverr;
        end
        else
        begin
            pslverr <= 1'b0;
        end
    end

endmodule

/* File: testbench/rmls_chk.sv */
// Checker of the ring mode and line status block, bound to its top.
// Assumes inputs synchronous to pclk and the bench host as bus master.
`timescale 1ns/1ps
module rmls_chk (
    input logic pclk, presetn, psel, penable, pwrite, pslverr, irq,
    input logic [11:0] paddr,
    input logic [31:0] pwdata, prdata,
    input logic [3:0] pstrb,
    input logic ring_validation_enable, half_wave_detect, full_wave_detect,
    input logic validated_envelope, rx_overload_level, offhook_counter_mask,
    input logic loop_current_flowing, offhook, line_side_enabled,
    input logic current_limit_setting, overcurrent_160ma, overcurrent_60ma,
    input logic ring_detect_pin
);
    // Shadows of the writable fields, so no check needs the hidden body.
    logic rsel;
    logic [3:0] msk;
    wire wr = psel && penable && pwrite && pstrb[0];
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rsel <= 1'b0;
            msk <= 4'h0;
        end
        else
        begin
            if (wr && paddr == 12'h048)
                rsel <= pwdata[1];
            if (wr && paddr == 12'h058)
                msk <= pwdata[3:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A read: setup on one edge, access on the next.
    sequence s_rd(a);
        psel && !penable && !pwrite && paddr == a ##1 psel && penable;
    endsequence
    ring_plain_a: assert property (!ring_validation_enable |=>
        ring_detect_pin == ($past(rsel) ? $past(full_wave_detect) : $past(half_wave_detect)))
        else $error("ring pin not from rectifier");
    ring_env_a: assert property (ring_validation_enable && !rsel |=>
        ring_detect_pin == $past(validated_envelope)) else $error("ring pin not envelope");
    mode_read_a: assert property (s_rd(12'h048) |->
        prdata == {30'h0, rsel, 1'b0}) else $error("mode read wrong");
    stat_rsvd_a: assert property (s_rd(12'h04c) |-> prdata[31:3] == 29'h0)
        else $error("status reserved bits set");
    overload_bit_a: assert property (s_rd(12'h04c) |-> prdata[2] ==
        ($past(rx_overload_level, 2) && !$past(offhook_counter_mask, 2)))
        else $error("overload bit");
    drop_bit_a: assert property (s_rd(12'h04c) |-> prdata[1] ==
        (!$past(loop_current_flowing, 2) ||
        (!$past(offhook, 2) && $past(line_side_enabled, 2))))
        else $error("dropout bit");
    ovc_bit_a: assert property (s_rd(12'h04c) |-> prdata[0] ==
        ($past(current_limit_setting, 2) ? $past(overcurrent_60ma, 2) :
        $past(overcurrent_160ma, 2)))
        else $error("overcurrent bit");
    unmapped_err_a: assert property (psel && penable &&
        !(paddr inside {12'h048, 12'h04c, 12'h050, 12'h054, 12'h058}) |->
        pslverr && prdata == 32'h0) else $error("unmapped access not refused");
    overload_clear_a: assert property (wr && paddr == 12'h050 && !pwdata[0] &&
        msk == 4'h1 && !rx_overload_level && !$past(rx_overload_level) &&
        !$past(rx_overload_level, 2)
        |=> !irq) else $error("overload flag not cleared");
endmodule
bind rmls_top rmls_chk u_chk (.*);

/* File: testbench/rmls_host.sv */
// Host model: an APB master issuing one transfer at a time.
// Assumes pclk from the bench; signals change just after rising edges.
`timescale 1ns/1ps
module rmls_host (
    input logic pclk, pready, pslverr,
    input logic [31:0] prdata,
    output logic psel, penable, pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb
);
    initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    // Call just after an edge; returns one edge after the access edge.
    task xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
              output logic [31:0] q, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (!pready)
            @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines must not keep showing the last request.
        paddr <= ~a;
        pwdata <= ~d;
        @(posedge pclk);
    endtask
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench of the ring mode and line status block.
// Assumes rmls_host as bus master and rmls_chk bound to the top.
`timescale 1ns/1ps
module tb_top;
    logic pclk = 0, presetn = 0, ring_validation_enable = 0, half_wave_detect = 0;
    logic full_wave_detect = 0, validated_envelope = 0, ring_threshold_cross = 0;
    logic rx_overload_level = 0, offhook_counter_mask = 0, loop_current_flowing = 1;
    logic offhook = 1, line_side_enabled = 0, current_limit_setting = 0;
    logic overcurrent_160ma = 0, overcurrent_60ma = 0;
    logic psel, penable, pwrite, pready, pslverr, ring_detect_pin, irq, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] pstrb;
    integer seed = 32'h807d1a2c, bad_count = 0, checks = 0, i, n;
    always #10 pclk = ~pclk;
    rmls_host h (.*);
    rmls_top #(.ONESHOT_CYCLES(20)) dut (.*);
    // Expected line status from the present detector inputs.
    function logic [31:0] st_exp();
        st_exp = {29'h0, rx_overload_level & !offhook_counter_mask,
            !loop_current_flowing | (!offhook & line_side_enabled),
            current_limit_setting ? overcurrent_60ma : overcurrent_160ma};
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task rd(input logic [11:0] a, input logic [31:0] x);
        h.xfer(a, 1'b0, 32'h0, q, e);
        chk(q, x);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        h.xfer(a, 1'b1, d, q, e);
    endtask
    task results;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(12'h048, 32'h0);
        rd(12'h04c, 32'h0);
        for (i = 0; i < 8; i++)
        begin
            wr(12'h048, {29'h0, i[1:0], 1'b0});
            ring_validation_enable <= i[2];
            rd(12'h048, {30'h0, i[0], 1'b0});
            for (n = 0; n < 4; n++)
            begin
                {half_wave_detect, full_wave_detect, validated_envelope} <= 3'($random(seed));
                repeat (2) @(posedge pclk);
                if (!(i[2] && i[0]))
                    chk(ring_detect_pin, i[2] ? validated_envelope :
                        i[0] ? full_wave_detect : half_wave_detect);
            end
        end
        $display("ring mode test done");
        ring_threshold_cross <= 1'b1;
        n = 0;
        repeat (40)
        begin
            @(posedge pclk);
            n += ring_detect_pin;
        end
        chk(n, 20);
        $display("one-shot test done");
        for (i = 0; i < 24; i++)
        begin
            {rx_overload_level, offhook_counter_mask, loop_current_flowing, offhook,
                line_side_enabled, current_limit_setting, overcurrent_160ma,
                overcurrent_60ma} <= 8'($random(seed));
            repeat (3) @(posedge pclk);
            if (i == 5)
                wr(12'h04c, 32'hff);
            rd(12'h04c, st_exp());
        end
        $display("status test done");
        {rx_overload_level, offhook_counter_mask, loop_current_flowing, offhook,
            line_side_enabled, overcurrent_160ma, overcurrent_60ma} <= 7'b0011000;
        wr(12'h058, 32'h0);
        h.xfer(12'h054, 1'b0, 32'h0, q, e);
        rd(12'h054, 32'h0);
        rx_overload_level <= 1'b1;
        repeat (3) @(posedge pclk);
        rx_overload_level <= 1'b0;
        chk(irq, 1'b0);
        wr(12'h058, 32'h1);
        chk(irq, 1'b1);
        rd(12'h050, 32'h1);
        wr(12'h050, 32'h0);
        rd(12'h050, 32'h0);
        chk(irq, 1'b0);
        rd(12'h05c, 32'h0);
        chk(e, 1'b1);
        // Dropout and overcurrent rises set their flags; one read clears both.
        {loop_current_flowing, overcurrent_160ma, overcurrent_60ma} <= 3'b011;
        repeat (3) @(posedge pclk);
        wr(12'h058, 32'h6);
        chk(irq, 1'b1);
        rd(12'h054, 32'h6);
        chk(irq, 1'b0);
        $display("interrupt test done");
        results;
    end
    // Cuts a hang short; the tests need far less than this.
    initial
    begin
        #400000;
        bad_count++;
        results;
    end
endmodule
